// ### testbench.sv
// Self-checking testbench for the watchdog timer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals and counters
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ctl_wr_i = 1'b0;
  logic [4:0] ctl_wdata_i = 5'h00;
  logic flag_clr_i = 1'b0;
  logic [4:0] ctl_rdata_o;
  logic warn_flag_o, irq_o, sys_rst_o, wdt_rst_flag_o, ext_rst_n_o, ext_rst_n_oe_o;
  logic [15:0] entry_addr_o;
  int bad_count = 0;
  int checked = 0;
  int seed = 30;
  int n;
  int lim;
  logic [31:0] r;
  logic [4:0] d;

  wdt_top i_wdt_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .ctl_wr_i(ctl_wr_i),
    .ctl_wdata_i(ctl_wdata_i), .flag_clr_i(flag_clr_i), .ctl_rdata_o(ctl_rdata_o),
    .warn_flag_o(warn_flag_o), .irq_o(irq_o), .sys_rst_o(sys_rst_o),
    .wdt_rst_flag_o(wdt_rst_flag_o), .ext_rst_n_o(ext_rst_n_o),
    .ext_rst_n_oe_o(ext_rst_n_oe_o), .entry_addr_o(entry_addr_o));

  // Clock of 40 ns
  always #20 clk_i = ~clk_i;

  // ==========================================================
  // Helpers
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #2;
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp, input string msg);
    checked++;
    if (got != exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %0d expected %0d", $time, msg, got, exp);
    end
  endtask
  // Control write, sampled at the next edge
  task automatic wr(input logic [4:0] v);
    ctl_wr_i = 1'b1;
    ctl_wdata_i = v;
    tick(1);
    ctl_wr_i = 1'b0;
  endtask
  task automatic clr_flag;
    flag_clr_i = 1'b1;
    tick(1);
    flag_clr_i = 1'b0;
  endtask
  // Count edges until the warning flag (0) or the system reset (1) is high
  task automatic wait_on(input int which);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (n < 40000 && (which == 0 ? warn_flag_o : sys_rst_o) !== 1'b1);
  endtask
  task automatic final_report;
    if (bad_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #3000000;
    bad_count++;
    final_report();
  end

  // ==========================================================
  // Main sequence
  initial begin
    tick(2);
    chk_val(ctl_rdata_o, 16'h0000, "control after reset");
    chk_val(sys_rst_o, 16'h0000, "reset request idle");
    chk_val(entry_addr_o, 16'h8000, "entry address");
    rst_n_i = 1'b1;
    // Readback of every interval code with random enables
    for (int s = 0; s < 4; s++) begin
      r = $random(seed);
      d = {1'b1, r[1:0], s[1:0]};
      wr(d);
      tick(1);
      chk_val(ctl_rdata_o, {11'h000, 1'b0, d[3:0]}, "readback");
    end
    // Timeout with warning and forced reset, intervals 0 and 1
    for (int s = 0; s < 2; s++) begin
      lim = (1 << (12 + 3 * s)) - 1;
      wr({3'h7, s[1:0]});
      wait_on(0);
      // Restart lands one edge after the write, the flag one edge after the warning count
      chk_cnt(n, lim - 512 + 2, "warning delay");
      chk_val(irq_o, 16'h0001, "irq with flag");
      wait_on(1);
      chk_cnt(n, 512, "warning lead");
      chk_val(ext_rst_n_oe_o, 16'h0001, "pin driven");
      chk_val(ext_rst_n_o, 16'h0000, "pin low");
      chk_val(wdt_rst_flag_o, 16'h0001, "reset cause");
      n = 0;
      while (sys_rst_o === 1'b1 && n < 100) begin
        tick(1);
        n++;
      end
      chk_cnt(n, 16, "reset pulse");
      chk_val(ext_rst_n_oe_o, 16'h0000, "pin released");
      chk_val(warn_flag_o, 16'h0000, "flag after reset");
      chk_val(entry_addr_o, 16'h8000, "entry after reset");
    end
    // Flag with interrupt and reset disabled, counter wraps
    wr(5'h10);
    wait_on(0);
    chk_cnt(n, 4095 - 512 + 2, "flag without enable");
    chk_val(irq_o, 16'h0000, "irq masked");
    clr_flag();
    chk_val(warn_flag_o, 16'h0000, "flag cleared");
    wait_on(0);
    chk_cnt(n, 4095, "flag after wrap");
    chk_val(sys_rst_o, 16'h0000, "no reset when disabled");
    // Random restarts keep the counter from its timeout
    clr_flag();
    wr(5'h1c);
    repeat (4) begin
      r = $random(seed);
      tick(1000 + int'(r[10:0]));
      wr(5'h1c);
    end
    chk_val(warn_flag_o, 16'h0000, "kept alive");
    chk_val(sys_rst_o, 16'h0000, "no reset when kept alive");
    // Reset in mid-run clears the cause flag and the control word
    rst_n_i = 1'b0;
    tick(2);
    chk_val(wdt_rst_flag_o, 16'h0000, "cause after second reset");
    chk_val(ctl_rdata_o, 16'h0000, "control after second reset");
    rst_n_i = 1'b1;
    tick(2);
    chk_val(sys_rst_o, 16'h0000, "idle after second reset");
    final_report();
  end
endmodule

// ### wdt_ctrl_if.sv
// Interface carrying the decoded control fields between modules
interface wdt_ctrl_if;
  logic [1:0] sel;
  logic irq_en;
  logic rst_en;
  logic restart;
  logic [wdt_pkg::CNT_W-1:0] limit;

  modport reg_side (output sel, output irq_en, output rst_en, output restart, output limit);
  modport core_side (input sel, input irq_en, input rst_en, input restart, input limit);
endinterface

// ### wdt_ctrl_reg.sv
// Watchdog control register and timeout limit decoder
module wdt_ctrl_reg (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic [4:0] wdata_i,
  wdt_ctrl_if.reg_side ctl
);
  logic [4:0] ctl_q;
  logic [4:0] ctl_d;
  logic restart_q;
  logic restart_d;

  // ==========================================================
  // Next value of the control register
  always_comb begin
    ctl_d = ctl_q;
    restart_d = 1'b0;
    if (wr_i) begin
      ctl_d = wdata_i;
      ctl_d[wdt_pkg::CTL_RESTART] = 1'b0;
      restart_d = wdata_i[wdt_pkg::CTL_RESTART];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctl_q <= wdt_pkg::CTL_RESET;
      restart_q <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      restart_q <= restart_d;
    end
  end

  // Field outputs and limit of 2^(12+3*sel) clocks minus one
  assign ctl.sel = ctl_q[wdt_pkg::CTL_SEL_LO +: 2];
  assign ctl.irq_en = ctl_q[wdt_pkg::CTL_IRQ_EN];
  assign ctl.rst_en = ctl_q[wdt_pkg::CTL_RST_EN];
  assign ctl.restart = restart_q;
  always_comb begin
    ctl.limit = '0;
    unique case (ctl_q[1:0])
      2'h0: ctl.limit = 21'h000fff;
      2'h1: ctl.limit = 21'h007fff;
      2'h2: ctl.limit = 21'h03ffff;
      2'h3: ctl.limit = 21'h1fffff;
    endcase
  end
endmodule

// ### wdt_pkg.sv
// Package of constants and types for the watchdog timer
package wdt_pkg;

  // ==========================================================
  // Counter sizing and timeouts
  localparam int CNT_W = 21;
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam int SEL_SHIFT_BASE = 12;
  localparam int SEL_SHIFT_STEP = 3;
  localparam logic [CNT_W-1:0] WARN_LEAD = 21'h000200;
  localparam logic [CNT_W-1:0] CNT_RESET = 21'h000000;

  // ==========================================================
  // Reset pulse and entry address
  localparam int RST_PULSE_CYC = 16;
  localparam logic [4:0] RST_PULSE_LAST = 5'h0f;
  localparam logic [15:0] RESET_ENTRY = 16'h8000;

  // ==========================================================
  // Control register bit positions
  localparam int CTL_SEL_LO = 0;
  localparam int CTL_IRQ_EN = 2;
  localparam int CTL_RST_EN = 3;
  localparam int CTL_RESTART = 4;
  localparam logic [4:0] CTL_RESET = 5'h00;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_FIRE
  } wdt_state_type;

endpackage

// ### wdt_top.sv
// Watchdog timer with early warning and forced system reset
// How it works
// - Free-running counter on system clock, restarted to zero by software.
// - Timeout without restart forces full reset; interrupt may come first.
// - Four selectable timeouts between 2^12 and 2^21 clocks.
// - Warning interrupt comes 512 clocks before the forced reset.
// - Software controls select, enables and restart through the control register.
// - After a watchdog reset, fetch resumes at address 8000h.
// - External reset pin is driven low during a watchdog reset.
// - Warning flag sets even when the interrupt is disabled.
module wdt_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ctl_wr_i,
  input wire logic [4:0] ctl_wdata_i,
  input wire logic flag_clr_i,
  output logic [4:0] ctl_rdata_o,
  output logic warn_flag_o,
  output logic irq_o,
  output logic sys_rst_o,
  output logic wdt_rst_flag_o,
  output logic ext_rst_n_o,
  output logic ext_rst_n_oe_o,
  output logic [15:0] entry_addr_o
);
  wdt_ctrl_if ctl ();

  wdt_ctrl_reg u_ctrl (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .wr_i(ctl_wr_i),
    .wdata_i(ctl_wdata_i),
    .ctl(ctl)
  );

  logic [wdt_pkg::CNT_W-1:0] cnt_q;
  logic [wdt_pkg::CNT_W-1:0] cnt_d;
  wdt_pkg::wdt_state_type st_q;
  wdt_pkg::wdt_state_type st_d;
  logic [4:0] pulse_q;
  logic [4:0] pulse_d;
  logic flag_q;
  logic flag_d;
  logic irq_q;
  logic irq_d;
  logic rst_q;
  logic rst_d;
  logic why_q;
  logic why_d;
  logic pin_q;
  logic pin_d;
  logic [4:0] rd_q;
  logic [4:0] rd_d;
  logic [15:0] entry_q;
  logic [15:0] entry_d;
  logic [9:0] lead_q;
  logic [9:0] lead_d;
  logic firing;
  logic warn_hit;
  logic end_hit;

  // ==========================================================
  // Counter and timeout detection
  assign firing = (st_q == wdt_pkg::ST_FIRE);
  assign warn_hit = (cnt_q == ctl.limit - wdt_pkg::WARN_LEAD);
  // At or past the limit, so a shorter interval chosen late still ends the count
  assign end_hit = (cnt_q >= ctl.limit);

  // Counter is held at zero while the reset pulse runs
  always_comb begin
    cnt_d = cnt_q + 21'h000001;
    if (ctl.restart || end_hit || firing) begin
      cnt_d = wdt_pkg::CNT_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= wdt_pkg::CNT_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================
  // Warning flag: set wins over clear
  always_comb begin
    flag_d = flag_q;
    if (flag_clr_i) begin
      flag_d = 1'b0;
    end
    if (warn_hit && !ctl.restart) begin
      flag_d = 1'b1;
    end
    if (firing) begin
      flag_d = 1'b0;
    end
    irq_d = flag_d && ctl.irq_en;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flag_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      irq_q <= irq_d;
    end
  end

  // ==========================================================
  // Reset pulse sequencer
  always_comb begin
    st_d = st_q;
    pulse_d = pulse_q;
    rst_d = 1'b0;
    why_d = why_q;
    unique case (st_q)
      wdt_pkg::ST_RUN: begin
        if (end_hit && !ctl.restart && ctl.rst_en) begin
          st_d = wdt_pkg::ST_FIRE;
          pulse_d = 5'h00;
          rst_d = 1'b1;
          why_d = 1'b1;
        end
      end
      wdt_pkg::ST_FIRE: begin
        rst_d = 1'b1;
        pulse_d = pulse_q + 5'h01;
        if (pulse_q == wdt_pkg::RST_PULSE_LAST) begin
          st_d = wdt_pkg::ST_RUN;
          rst_d = 1'b0;
        end
      end
      default: st_d = wdt_pkg::ST_RUN;
    endcase
    pin_d = !rst_d;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q <= wdt_pkg::ST_RUN;
      pulse_q <= 5'h00;
      rst_q <= 1'b0;
      why_q <= 1'b0;
      pin_q <= 1'b1;
    end else begin
      st_q <= st_d;
      pulse_q <= pulse_d;
      rst_q <= rst_d;
      why_q <= why_d;
      pin_q <= pin_d;
    end
  end

  // ==========================================================
  // Readback word and fixed fetch entry, both registered
  always_comb begin
    rd_d = {1'b0, ctl.rst_en, ctl.irq_en, ctl.sel};
    entry_d = wdt_pkg::RESET_ENTRY;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_q <= wdt_pkg::CTL_RESET;
      entry_q <= wdt_pkg::RESET_ENTRY;
    end else begin
      rd_q <= rd_d;
      entry_q <= entry_d;
    end
  end

  // ==========================================================
  // Check helper: cycles since the warning, dropped by restart or pulse
  always_comb begin
    lead_d = lead_q;
    if (ctl.restart || firing) begin
      lead_d = 10'h000;
    end else if (warn_hit) begin
      lead_d = 10'h001;
    end else if (lead_q != 10'h000 && lead_q != 10'h3ff) begin
      lead_d = lead_q + 10'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lead_q <= 10'h000;
    end else begin
      lead_q <= lead_d;
    end
  end

  // Outputs straight from flip-flops
  assign ctl_rdata_o = rd_q;
  assign warn_flag_o = flag_q;
  assign irq_o = irq_q;
  assign sys_rst_o = rst_q;
  assign wdt_rst_flag_o = why_q;
  assign ext_rst_n_o = pin_q;
  assign ext_rst_n_oe_o = rst_q;
  assign entry_addr_o = entry_q;

  // ==========================================================
  // Checks
  sequence s_fire;
    $rose(rst_q);
  endsequence

  a_warn_sets_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (warn_hit && !ctl.restart && st_q == wdt_pkg::ST_RUN) |=> flag_q)
    else $error("warning flag not set");
  a_reset_after_end: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (end_hit && !ctl.restart && ctl.rst_en && st_q == wdt_pkg::ST_RUN) |=> rst_q)
    else $error("reset not forced at timeout");
  a_pulse_length: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_fire |-> (ext_rst_n_oe_o && !ext_rst_n_o) [*8])
    else $error("reset pin pulse too short");
  a_restart_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ctl.restart && st_q == wdt_pkg::ST_RUN) |=> cnt_q == 21'h000000)
    else $error("restart did not clear counter");
  a_counter_runs: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!ctl.restart && !end_hit && st_q == wdt_pkg::ST_RUN) |=> cnt_q == $past(cnt_q) + 21'h1)
    else $error("counter did not advance");
  a_no_overrun: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cnt_q <= ctl.limit || $past(ctl_wr_i))
    else $error("counter past selected limit");
  a_irq_gated: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    irq_q |-> flag_q)
    else $error("interrupt without flag");
  a_warn_lead: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_fire |-> lead_q == 10'(wdt_pkg::WARN_LEAD) + 10'h001)
    else $error("warning lead wrong");
  a_entry_fixed: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    entry_addr_o == 16'h8000)
    else $error("entry address wrong");
endmodule
